// [design/ckc_top.v]
// Clock controller: special-register port, CPU/peripheral/USB clock enables and synthesizer.
// Assumes clk_i samples the crystal pin; all derived clocks are one-cycle enables on clk_i.
// The power mode comes from the power manager on the same clock.
`timescale 1ns/1ns
`include "ckc_regs.vh"

module ckc_top (
	input wire clk_i,                 // System clock, 125 MHz
	input wire rstn_i,                // Synchronous reset, active low
	input wire xtal_input_pin_i,      // Crystal or external 48 MHz clock pin
	input wire [7:0] sfr_addr_i,      // Special-register address
	input wire [7:0] sfr_wdata_i,     // Write data
	input wire sfr_wr_i,              // Write strobe, one cycle
	input wire sfr_rd_i,              // Read strobe, one cycle
	input wire [1:0] pwr_mode_i,      // Power reduction mode
	output reg [7:0] sfr_rdata_o,     // Read data, valid cycle after strobe
	output reg sfr_hit_o,             // Read address belonged to this block
	output reg cpu_clk_en_o,          // CPU core clock enable
	output reg periph_clk_en_o,       // General peripheral and port sampling enable
	output reg [7:0] periph_tick_o,   // Per-peripheral clock enables
	output reg usb_clk_en_o,          // USB controller clock enable
	output reg osc_inv_en_o,          // Oscillator inverter enable
	output reg charge_pump_up_o,      // Charge pump up drive
	output reg charge_pump_dn_o,      // Charge pump down drive
	output reg synth_locked_o         // Synthesizer lock status
);

	// Decode of one special-register address
	function addr_hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			addr_hit = (addr == target);
		end
	endfunction

	// Software-visible registers
	reg [7:0] speed0_reg;
	reg speed1_spi_reg;
	reg synth_enable_reg;
	reg bypass_reg;
	reg [7:0] divider_reg;

	// Crystal pin synchroniser and edge detect
	reg xtal_s1_reg;
	reg xtal_s2_reg;
	reg xtal_s3_reg;
	wire osc_tick;

	// Half-rate phase for standard-speed timing
	reg half_phase_reg;
	wire half_tick;
	wire cpu_tick;
	wire periph_base_tick;
	wire [7:0] periph_sel;
	wire [7:0] periph_fast;
	wire [7:0] periph_tick_next;

	// Synthesizer
	reg [15:0] vco_inc_reg;
	reg [16:0] vco_acc_reg;
	wire vco_tick;
	wire ref_tick;
	wire fb_tick;
	wire pfd_up;
	wire pfd_dn;
	wire pfd_locked;
	wire synth_run;
	wire usb_src_tick;

	// Power gating
	wire cpu_gate;
	wire periph_gate;
	wire usb_gate;

	wire wr_speed0;
	wire wr_speed1;
	wire wr_synctrl;
	wire wr_syndiv;

	assign wr_speed0 = sfr_wr_i & addr_hit(sfr_addr_i, `CKC_ADDR_SPEED0);
	assign wr_speed1 = sfr_wr_i & addr_hit(sfr_addr_i, `CKC_ADDR_SPEED1);
	assign wr_synctrl = sfr_wr_i & addr_hit(sfr_addr_i, `CKC_ADDR_SYNCTRL);
	assign wr_syndiv = sfr_wr_i & addr_hit(sfr_addr_i, `CKC_ADDR_SYNDIV);

	// Register writes
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			speed0_reg <= `CKC_RST_BYTE;
			speed1_spi_reg <= 1'b0;
			synth_enable_reg <= 1'b0;
			bypass_reg <= 1'b0;
			divider_reg <= `CKC_RST_BYTE;
		end else begin
			if (wr_speed0) begin
				speed0_reg <= sfr_wdata_i;
			end
			if (wr_speed1) begin
				// Upper bits are not stored, so they can never read back as one
				speed1_spi_reg <= sfr_wdata_i[`CKC_BIT_SPI];
			end
			if (wr_synctrl) begin
				// Lock bit is owned by the detector; write data for it is dropped
				synth_enable_reg <= sfr_wdata_i[`CKC_BIT_ENABLE];
				bypass_reg <= sfr_wdata_i[`CKC_BIT_BYPASS];
			end
			if (wr_syndiv) begin
				divider_reg <= sfr_wdata_i;
			end
		end
	end

	// Register reads, registered one cycle after the strobe
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			sfr_rdata_o <= `CKC_ZERO_BYTE;
			sfr_hit_o <= 1'b0;
		end else if (sfr_rd_i) begin
			sfr_hit_o <= 1'b1;
			case (sfr_addr_i)
				`CKC_ADDR_SPEED0: begin
					sfr_rdata_o <= speed0_reg;
				end
				`CKC_ADDR_SPEED1: begin
					sfr_rdata_o <= {7'h00, speed1_spi_reg};
				end
				`CKC_ADDR_SYNCTRL: begin
					sfr_rdata_o <= {5'h00, bypass_reg, synth_enable_reg, pfd_locked};
				end
				`CKC_ADDR_SYNDIV: begin
					sfr_rdata_o <= divider_reg;
				end
				default: begin
					sfr_rdata_o <= `CKC_ZERO_BYTE;
					sfr_hit_o <= 1'b0;
				end
			endcase
		end else begin
			sfr_rdata_o <= `CKC_ZERO_BYTE;
			sfr_hit_o <= 1'b0;
		end
	end

	// Pin passes three flops; edge detect looks only at the second and third
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			xtal_s1_reg <= 1'b0;
			xtal_s2_reg <= 1'b0;
			xtal_s3_reg <= 1'b0;
		end else begin
			xtal_s1_reg <= xtal_input_pin_i;
			xtal_s2_reg <= xtal_s1_reg;
			xtal_s3_reg <= xtal_s2_reg;
		end
	end

	// One tick per oscillator period, whether crystal or external 48 MHz source
	assign osc_tick = xtal_s2_reg & ~xtal_s3_reg;

	always @(posedge clk_i) begin
		if (!rstn_i) begin
			half_phase_reg <= 1'b0;
		end else if (osc_tick) begin
			half_phase_reg <= ~half_phase_reg;
		end
	end

	assign half_tick = osc_tick & half_phase_reg;

	// Standard speed runs at half the oscillator rate, double speed at the full rate
	assign cpu_tick = speed0_reg[`CKC_BIT_DOUBLE] ? osc_tick : half_tick;
	assign periph_base_tick = cpu_tick;

	assign periph_sel = {speed0_reg[`CKC_BIT_TWOWIRE:`CKC_BIT_TIMER0], speed1_spi_reg};

	// Bit order of periph_tick_o: 7 two-wire .. 1 timer0, 0 SPI
	genvar gi;
	generate
		for (gi = 0; gi < `CKC_NUM_PERIPH; gi = gi + 1) begin : g_periph
			// A set selector halves the rate, but only once double speed is on
			assign periph_fast[gi] = speed0_reg[`CKC_BIT_DOUBLE] & ~periph_sel[gi];
			assign periph_tick_next[gi] = periph_fast[gi] ? osc_tick : half_tick;
		end
	endgenerate

	// Power gating of the three clocks
	assign cpu_gate = (pwr_mode_i == `CKC_PWR_RUN);
	assign periph_gate = (pwr_mode_i == `CKC_PWR_RUN) | (pwr_mode_i == `CKC_PWR_IDLE);
	// USB keeps its clock in idle so bus events can still be seen
	assign usb_gate = periph_gate;

	// Synthesizer: numerically controlled oscillator steered by the comparator
	assign synth_run = synth_enable_reg & ~bypass_reg;

	always @(posedge clk_i) begin
		if (!rstn_i || !synth_run) begin
			vco_inc_reg <= `CKC_VCO_INIT;
			vco_acc_reg <= 17'h0_0000;
		end else begin
			vco_acc_reg <= {1'b0, vco_acc_reg[15:0]} + {1'b0, vco_inc_reg};
			// Rate moves one step per cycle of phase error; clamped to a sane range
			if (pfd_up && !pfd_dn && vco_inc_reg < `CKC_VCO_MAX) begin
				vco_inc_reg <= vco_inc_reg + `CKC_VCO_STEP;
			end else if (pfd_dn && !pfd_up && vco_inc_reg > `CKC_VCO_MIN) begin
				vco_inc_reg <= vco_inc_reg - `CKC_VCO_STEP;
			end
		end
	end

	assign vco_tick = vco_acc_reg[16];

	ckc_divider u_ref_div (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.en_i(synth_run),
		.tick_i(osc_tick),
		.ratio_i(divider_reg[`CKC_REF_MSB:`CKC_REF_LSB]),
		.tick_o(ref_tick)
	);

	ckc_divider u_fb_div (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.en_i(synth_run),
		.tick_i(vco_tick),
		.ratio_i(divider_reg[`CKC_FB_MSB:`CKC_FB_LSB]),
		.tick_o(fb_tick)
	);

	ckc_phase_cmp u_phase_cmp (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.en_i(synth_run),
		.ref_tick_i(ref_tick),
		.fb_tick_i(fb_tick),
		.up_o(pfd_up),
		.dn_o(pfd_dn),
		.locked_o(pfd_locked)
	);

	// USB source: external clock when bypassed, synthesizer output otherwise
	assign usb_src_tick = bypass_reg ? osc_tick : (synth_run & vco_tick);

	// Registered outputs
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			cpu_clk_en_o <= 1'b0;
			periph_clk_en_o <= 1'b0;
			periph_tick_o <= `CKC_ZERO_BYTE;
			usb_clk_en_o <= 1'b0;
			osc_inv_en_o <= 1'b0;
			charge_pump_up_o <= 1'b0;
			charge_pump_dn_o <= 1'b0;
			synth_locked_o <= 1'b0;
		end else begin
			cpu_clk_en_o <= cpu_tick & cpu_gate;
			periph_clk_en_o <= periph_base_tick & periph_gate;
			periph_tick_o <= periph_gate ? periph_tick_next : `CKC_ZERO_BYTE;
			usb_clk_en_o <= usb_src_tick & usb_gate;
			// Inverter runs whenever the synthesizer path is the USB source, enabled or not
			osc_inv_en_o <= ~bypass_reg;
			charge_pump_up_o <= pfd_up;
			charge_pump_dn_o <= pfd_dn;
			synth_locked_o <= pfd_locked;
		end
	end

endmodule // ckc_top

// [design/ckc_regs.vh]
// Register map, field positions, reset values and constants of the clock controller.
// Assumes an 8-bit special-register port and a single 125 MHz system clock.
//
// What this block does
// - Three clock outputs: CPU, peripheral, USB
// - Crystal pin also accepts external 48 MHz
// - Oscillator inverter off only when bypass bit selects external clock
// - Phase comparator emits up/down from edge order
// - synth_enable bit 1 starts and stops synthesizer
// - synth_locked bit 0 follows lock detector
// - Bypass bit 2 selects external USB clock
// - cpu_double_speed bit 0: CPU tick every 2 or 1 oscillator periods
// - Peripheral timing bits act only in double speed
// - Peripheral timing bits placed in register 0
// - SPI timing bit 0 of register 1
// - Unused upper bits read zero
// - Control registers reset to all zeros
// - Output clocks gated by power mode
`ifndef CKC_REGS_VH
`define CKC_REGS_VH

`define CKC_ADDR_SPEED0     8'h8F
`define CKC_ADDR_SYNCTRL    8'hA3
`define CKC_ADDR_SYNDIV     8'hA4
`define CKC_ADDR_SPEED1     8'hAF

`define CKC_RST_BYTE        8'h00
`define CKC_ZERO_BYTE       8'h00

`define CKC_BIT_DOUBLE      0
`define CKC_BIT_TIMER0      1
`define CKC_BIT_TIMER1      2
`define CKC_BIT_TIMER2      3
`define CKC_BIT_UART        4
`define CKC_BIT_COUNTER     5
`define CKC_BIT_WATCHDOG    6
`define CKC_BIT_TWOWIRE     7
`define CKC_BIT_SPI         0

`define CKC_BIT_LOCKED      0
`define CKC_BIT_ENABLE      1
`define CKC_BIT_BYPASS      2

`define CKC_FB_MSB          7
`define CKC_FB_LSB          4
`define CKC_REF_MSB         3
`define CKC_REF_LSB         0

`define CKC_PWR_RUN         2'h0
`define CKC_PWR_IDLE        2'h1
`define CKC_PWR_DOWN        2'h2

`define CKC_NUM_PERIPH      8

`define CKC_VCO_INIT        16'h6000
`define CKC_VCO_MIN         16'h0400
`define CKC_VCO_MAX         16'hF000
`define CKC_VCO_STEP        16'h0001

`define CKC_LOCK_WIN        8'h03
`define CKC_LOCK_CNT        8'h10
`define CKC_ERR_MAX         8'hFF

`endif

// [design/ckc_divider.v]
// Tick divider: passes one tick out of every ratio+1 ticks in.
// Assumes tick_i is a one-cycle enable on clk_i; ratio changes apply from the next input tick.
`timescale 1ns/1ns
`include "ckc_regs.vh"

module ckc_divider (
	input wire clk_i,        // System clock
	input wire rstn_i,       // Synchronous reset, active low
	input wire en_i,         // Divider running
	input wire tick_i,       // Input tick
	input wire [3:0] ratio_i, // Divide ratio minus one
	output reg tick_o        // Divided tick, one cycle
);

	reg [3:0] count_reg;

	always @(posedge clk_i) begin
		if (!rstn_i || !en_i) begin
			count_reg <= 4'h0;
			tick_o <= 1'b0;
		end else begin
			tick_o <= 1'b0;
			if (tick_i) begin
				if (count_reg >= ratio_i) begin
					count_reg <= 4'h0;
					tick_o <= 1'b1;
				end else begin
					count_reg <= count_reg + 4'h1;
				end
			end
		end
	end

endmodule // ckc_divider

// [design/ckc_phase_cmp.v]
// Phase/frequency comparator with lock detector for the clock synthesizer.
// Assumes ref and feedback ticks are one-cycle pulses on clk_i.
`timescale 1ns/1ns
`include "ckc_regs.vh"

module ckc_phase_cmp (
	input wire clk_i,       // System clock
	input wire rstn_i,      // Synchronous reset, active low
	input wire en_i,        // Synthesizer enabled
	input wire ref_tick_i,  // Reference divider output
	input wire fb_tick_i,   // Feedback divider output
	output reg up_o,        // Feedback lags, speed up
	output reg dn_o,        // Feedback leads, slow down
	output reg locked_o     // Lock indicator
);

	reg [7:0] err_reg;
	reg [7:0] good_reg;
	wire up_next;
	wire dn_next;
	wire resolve;

	// Whichever edge arrives first opens its pulse; the other edge closes both
	assign up_next = up_o | ref_tick_i;
	assign dn_next = dn_o | fb_tick_i;
	assign resolve = up_next & dn_next;

	always @(posedge clk_i) begin
		if (!rstn_i || !en_i) begin
			up_o <= 1'b0;
			dn_o <= 1'b0;
			err_reg <= 8'h00;
			good_reg <= 8'h00;
			locked_o <= 1'b0;
		end else begin
			up_o <= up_next & ~resolve;
			dn_o <= dn_next & ~resolve;
			if (resolve) begin
				err_reg <= 8'h00;
				if (err_reg <= `CKC_LOCK_WIN) begin
					if (good_reg >= `CKC_LOCK_CNT) begin
						locked_o <= 1'b1;
					end else begin
						good_reg <= good_reg + 8'h01;
					end
				end else begin
					good_reg <= 8'h00;
					locked_o <= 1'b0;
				end
			end else if (up_next | dn_next) begin
				if (err_reg != `CKC_ERR_MAX) begin
					err_reg <= err_reg + 8'h01;
				end
				// Drop lock as soon as the phase error grows past the window
				if (err_reg >= `CKC_LOCK_WIN) begin
					good_reg <= 8'h00;
					locked_o <= 1'b0;
				end
			end
		end
	end

endmodule // ckc_phase_cmp

// [test/ckc_properties.sv]
// Concurrent checks on the clock controller ports.
// Assumes it is bound onto ckc_top and sees only its ports.
`timescale 1ns/1ns
`include "ckc_regs.vh"
module ckc_properties (
	input wire clk_i, // System clock
	input wire rstn_i, // Reset, active low
	input wire [7:0] sfr_addr_i, // Address
	input wire [7:0] sfr_wdata_i, // Write data
	input wire sfr_wr_i, // Write strobe
	input wire sfr_rd_i, // Read strobe
	input wire [1:0] pwr_mode_i, // Power mode
	input wire [7:0] sfr_rdata_o, // Read data
	input wire sfr_hit_o, // Read hit
	input wire cpu_clk_en_o, // CPU enable
	input wire periph_clk_en_o, // Peripheral enable
	input wire [7:0] periph_tick_o, // Peripheral ticks
	input wire usb_clk_en_o, // USB enable
	input wire osc_inv_en_o, // Inverter enable
	input wire synth_locked_o // Lock status
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	wire mapped = (sfr_addr_i == `CKC_ADDR_SPEED0) || (sfr_addr_i == `CKC_ADDR_SYNCTRL) ||
		(sfr_addr_i == `CKC_ADDR_SYNDIV) || (sfr_addr_i == `CKC_ADDR_SPEED1);
	sequence s_ctl_write;
		sfr_wr_i && sfr_addr_i == `CKC_ADDR_SYNCTRL ##1 !sfr_wr_i;
	endsequence
	sequence s_synth_off;
		!osc_inv_en_o [*4];
	endsequence
	a_read_hit_map: assert property (sfr_rd_i |=> sfr_hit_o == $past(mapped))
		else $error("hit flag wrong");
	a_unmapped_zero: assert property (sfr_rd_i && !mapped |=> sfr_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_idle_bus_zero: assert property (!sfr_rd_i |=> sfr_rdata_o == 8'h00 && !sfr_hit_o)
		else $error("read bus not idle");
	a_spi_reg_zero: assert property (sfr_rd_i && sfr_addr_i == `CKC_ADDR_SPEED1 |=> sfr_rdata_o[7:1] == 7'h00)
		else $error("reserved bits set");
	a_ctl_reg_zero: assert property (sfr_rd_i && sfr_addr_i == `CKC_ADDR_SYNCTRL |=> sfr_rdata_o[7:3] == 5'h00)
		else $error("reserved bits set");
	a_inverter_follow: assert property (s_ctl_write |=> osc_inv_en_o == !$past(sfr_wdata_i[2], 2))
		else $error("inverter enable wrong");
	a_lock_drop: assert property ($fell(osc_inv_en_o) |-> ##[0:2] !synth_locked_o)
		else $error("lock kept after stop");
	a_lock_needs_synth: assert property (s_synth_off |-> !synth_locked_o)
		else $error("lock without synthesizer");
	a_down_quiet: assert property (pwr_mode_i[1] [*3] |-> !cpu_clk_en_o && !periph_clk_en_o && !usb_clk_en_o && periph_tick_o == 8'h00)
		else $error("clock in power down");
	a_idle_cpu_off: assert property ((pwr_mode_i == `CKC_PWR_IDLE) [*3] |-> !cpu_clk_en_o)
		else $error("cpu clock in idle");
	a_cpu_single: assert property (cpu_clk_en_o |=> !cpu_clk_en_o)
		else $error("cpu pulse too long");
	a_tick_in_periph: assert property (periph_tick_o != 8'h00 || cpu_clk_en_o |-> periph_clk_en_o)
		else $error("tick off peripheral phase");
endmodule // ckc_properties

// [test/ckc_xtal_model.sv]
// Crystal or external clock source on the oscillator pin.
// Assumes the pin is sampled by a much faster system clock.
`timescale 1ns/1ns
module ckc_xtal_model #(parameter HALF_NS = 44) (
	output reg pin_o // Oscillator pin
);
	// Free running like a resonator; rate kept well under 32 MHz
	initial begin
		pin_o = 1'b0;
		#3;
		forever #HALF_NS pin_o = ~pin_o;
	end
endmodule // ckc_xtal_model

// [test/test_ckc_top.sv]
// Self-checking bench of the clock controller with a register model.
// Assumes the crystal model drives the pin off the clock edges.
`timescale 1ns/1ns
`include "ckc_regs.vh"
module test_ckc_top;
	localparam int K = 8;
	localparam [47:0] ADDRS = 48'h8FA3_A4AF_8EA5;
	reg clk_i, rstn_i, sfr_wr_i, sfr_rd_i, win;
	reg [7:0] sfr_addr_i, sfr_wdata_i, m_s0, m_ctl, m_div, m_s1, sel;
	reg [1:0] pwr_mode_i;
	wire xtal, cpu, per, usb, inv, hit, lck, pup, pdn;
	wire [7:0] rdata, tick;
	int err_count, checks_done, cyc, j, k, n_cpu, n_per, n_usb, act, run, dbl;
	int n_tick [8];
	ckc_xtal_model u_xtal (.pin_o(xtal));
	ckc_top u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .xtal_input_pin_i(xtal), .sfr_addr_i(sfr_addr_i),
		.sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .pwr_mode_i(pwr_mode_i),
		.sfr_rdata_o(rdata), .sfr_hit_o(hit), .cpu_clk_en_o(cpu), .periph_clk_en_o(per), .periph_tick_o(tick),
		.usb_clk_en_o(usb), .osc_inv_en_o(inv), .charge_pump_up_o(pup), .charge_pump_dn_o(pdn),
		.synth_locked_o(lck));
	task results; begin
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	end endtask
	task check(input string nm, input [31:0] seen, input [31:0] exp); begin
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	end endtask
	task wr(input [7:0] a, input [7:0] d); begin
		sfr_addr_i <= a;
		sfr_wdata_i <= d;
		sfr_wr_i <= 1'b1;
		@(posedge clk_i);
		sfr_wr_i <= 1'b0;
		// Let one edge pass so a following write never re-raises the strobe in this step
		@(posedge clk_i);
		case (a)
			`CKC_ADDR_SPEED0: m_s0 = d;
			`CKC_ADDR_SYNCTRL: m_ctl = d & 8'h06;
			`CKC_ADDR_SYNDIV: m_div = d;
			`CKC_ADDR_SPEED1: m_s1 = d & 8'h01;
			default: ;
		endcase
	end endtask
	// Lock is read only while stopped or bypassed, so model bit 0 stays clear
	task rd(input [7:0] a); begin
		sfr_addr_i <= a;
		sfr_rd_i <= 1'b1;
		@(posedge clk_i);
		sfr_rd_i <= 1'b0;
		#1;
		case (a)
			`CKC_ADDR_SPEED0: check("speed0", rdata, m_s0);
			`CKC_ADDR_SYNCTRL: check("synctrl", rdata, m_ctl);
			`CKC_ADDR_SYNDIV: check("syndiv", rdata, m_div);
			`CKC_ADDR_SPEED1: check("speed1", rdata, m_s1);
			default: check("unmapped", rdata, 0);
		endcase
		check("hit", hit, a != 8'h8E && a != 8'hA5);
		@(posedge clk_i);
	end endtask
	// Window opens and closes on pin edges, so it holds exactly K oscillator ticks
	task measure; begin
		@(posedge xtal);
		n_cpu = 0;
		n_per = 0;
		n_usb = 0;
		foreach (n_tick[i]) n_tick[i] = 0;
		win = 1;
		repeat (K) @(posedge xtal);
		win = 0;
	end endtask
	always @(posedge clk_i) begin
		if (win) begin
			n_cpu += cpu;
			n_per += per;
			n_usb += usb;
			foreach (n_tick[i]) n_tick[i] += tick[i];
		end
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			results;
		end
	end
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	initial begin
		{rstn_i, sfr_wr_i, sfr_rd_i, win, sfr_addr_i, sfr_wdata_i, pwr_mode_i} = 0;
		{m_s0, m_ctl, m_div, m_s1} = 0;
		void'($urandom(32'hce3c_143a));
		repeat (3) @(posedge clk_i);
		rstn_i <= 1'b1;
		for (j = 0; j < 6; j++) rd(ADDRS[8*(5-j) +: 8]);
		wr(`CKC_ADDR_SYNCTRL, 8'hFF);
		wr(`CKC_ADDR_SPEED1, 8'hFF);
		wr(`CKC_ADDR_SYNDIV, 8'($urandom));
		wr(8'hA5, 8'($urandom));
		for (j = 0; j < 6; j++) rd(ADDRS[8*(5-j) +: 8]);
		wr(`CKC_ADDR_SYNDIV, 8'h30);
		for (j = 0; j < 4; j++) begin
			wr(`CKC_ADDR_SYNCTRL, 8'(2*j));
			repeat (30) @(posedge clk_i);
			check("osc_inv", inv, j < 2);
			measure;
			if (j != 1) check("usb_src", n_usb, (j > 1) ? K : 0);
			if (j != 1) check("lock", lck, 0);
			if (j != 1) check("pump", {pup, pdn}, 0);
		end
		for (j = 0; j < 8; j++) begin
			wr(`CKC_ADDR_SPEED0, (j == 0) ? 8'h01 : 8'($urandom));
			wr(`CKC_ADDR_SPEED1, 8'($urandom));
			pwr_mode_i <= (j < 2) ? 2'h0 : 2'($urandom);
			rd(`CKC_ADDR_SPEED0);
			rd(`CKC_ADDR_SPEED1);
			repeat (30) @(posedge clk_i);
			measure;
			dbl = m_s0[0];
			run = pwr_mode_i == 2'h0;
			act = !pwr_mode_i[1];
			sel = {m_s0[7:1], m_s1[0]};
			check("cpu", n_cpu, run ? (dbl ? K : K/2) : 0);
			check("periph", n_per, act ? (dbl ? K : K/2) : 0);
			for (k = 0; k < 8; k++) check("tick", n_tick[k], act ? ((dbl && !sel[k]) ? K : K/2) : 0);
			check("usb", n_usb, act ? K : 0);
		end
		results;
	end
endmodule // test_ckc_top
bind ckc_top ckc_properties u_props (.*);
